// >>> core/updown_pkg.sv
// constants and types shared by the up-down and latched run control
package updown_pkg;
  localparam int TERM_COUNT = 5;
  localparam int FUNC_W = 6;
  localparam int FREQ_W = 16;
  // input function selector codes
  localparam logic [5:0] FUNC_UP = 6'h11;
  localparam logic [5:0] FUNC_DOWN = 6'h12;
  localparam logic [5:0] FUNC_UD_CLEAR = 6'h14;
  localparam logic [5:0] FUNC_UD_ENABLE = 6'h1B;
  localparam logic [5:0] FUNC_LATCHED_RUN = 6'h0E;
  localparam logic [5:0] FUNC_FWD_RUN = 6'h01;
  localparam logic [5:0] FUNC_REV_RUN = 6'h02;
  localparam logic [5:0] FUNC_NONE = 6'h00;
  // reset values
  localparam logic [15:0] FREQ_RESET = 16'h0000;
  localparam logic [15:0] MAX_FREQ_RESET = 16'h1770;
  localparam logic [15:0] STEP_RESET = 16'h0001;
  // timing: ramp tick period and least command pulse
  localparam int CLK_HZ = 25_000_000;
  localparam int RAMP_TICK_US = 1000;
  localparam int RAMP_TICK_CYCLES = (CLK_HZ / 1_000_000) * RAMP_TICK_US;
  localparam int MIN_PULSE_US = 1000;
  localparam int MIN_PULSE_CYCLES = (CLK_HZ / 1_000_000) * MIN_PULSE_US;
  localparam int TICK_W = 16;
  // register map, byte offsets
  localparam logic [7:0] ADDR_FUNC_BASE = 8'h00;
  localparam logic [7:0] ADDR_SAVE_MODE = 8'h14;
  localparam logic [7:0] ADDR_MAX_FREQ = 8'h18;
  localparam logic [7:0] ADDR_STEP = 8'h1C;
  localparam logic [7:0] ADDR_KEYPAD_FREQ = 8'h20;
  localparam logic [7:0] ADDR_SOURCE = 8'h24;
  localparam logic [7:0] ADDR_STATUS = 8'h28;
  localparam logic [7:0] ADDR_OUT_FREQ = 8'h2C;
  localparam logic [7:0] ADDR_SAVED_FREQ = 8'h30;
  // frequency reference source selection
  localparam logic [1:0] SRC_KEYPAD = 2'h0;
  localparam logic [1:0] SRC_ANALOG = 2'h1;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RAMP_UP = 4'b0010,
    ST_RAMP_DOWN = 4'b0100,
    ST_HOLD = 4'b1000
  } ramp_state_t;
endpackage

// >>> core/input_sync.sv
// three-stage synchroniser with agreement filter for terminal inputs
module input_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // pins
  input wire logic [updown_pkg::TERM_COUNT-1:0] pin_in,
  // filtered levels
  output logic [updown_pkg::TERM_COUNT-1:0] level
);
  logic [updown_pkg::TERM_COUNT-1:0] stage1;
  logic [updown_pkg::TERM_COUNT-1:0] stage2;
  logic [updown_pkg::TERM_COUNT-1:0] stage3;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else if (clk_en) begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  genvar i;
  generate
    for (i = 0; i < updown_pkg::TERM_COUNT; i++) begin : g_bit
      // a change counts once stages two and three agree
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          level[i] <= 1'b0;
        end else if (clk_en && (stage2[i] == stage3[i])) begin
          level[i] <= stage3[i];
        end
      end
    end
  endgenerate
endmodule // input_sync

// >>> core/updown_run_ctrl.sv
// up-down frequency control and latched push-button run control
//
// Decided for this implementation: the plain strobed port and the address map.
module updown_run_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // terminals
  input wire logic [updown_pkg::TERM_COUNT-1:0] term_in,
  // drive state
  input wire logic fault_trip,
  input wire logic power_fail,
  input wire logic [15:0] analog_voltage_reference,
  input wire logic [15:0] normal_ramp_freq,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // results
  output logic [15:0] freq_ref,
  output logic run_fwd,
  output logic run_rev,
  output logic updown_active
);
  logic [updown_pkg::TERM_COUNT-1:0] term;
  logic [5:0] input_function_assignment [updown_pkg::TERM_COUNT];
  logic save_mode;
  logic [15:0] max_freq;
  logic [15:0] step;
  logic [15:0] keypad_freq;
  logic [1:0] source_sel;
  logic [15:0] ud_freq;
  logic [15:0] saved_freq;
  logic saved_valid;
  logic [15:0] tick_cnt;
  logic tick;
  logic fault_d;
  logic power_d;
  logic run_d;
  logic fwd_latch;
  logic rev_latch;
  logic ud_en_d;
  updown_pkg::ramp_state_t state;
  updown_pkg::ramp_state_t next_state;
  logic up_in, down_in, en_in, clr_in, latch_in, forward_run_command, rev_in;
  logic run_cmd;
  logic [16:0] up_sum;

  input_sync u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .pin_in(term_in),
    .level(term)
  );

  // decode each terminal by its function selector
  always_comb begin
    up_in = 1'b0;
    down_in = 1'b0;
    en_in = 1'b0;
    clr_in = 1'b0;
    latch_in = 1'b0;
    forward_run_command = 1'b0;
    rev_in = 1'b0;
    for (int i = 0; i < updown_pkg::TERM_COUNT; i++) begin
      if (term[i]) begin
        unique case (input_function_assignment[i])
          updown_pkg::FUNC_UP: up_in = 1'b1;
          updown_pkg::FUNC_DOWN: down_in = 1'b1;
          updown_pkg::FUNC_UD_ENABLE: en_in = 1'b1;
          updown_pkg::FUNC_UD_CLEAR: clr_in = 1'b1;
          updown_pkg::FUNC_LATCHED_RUN: latch_in = 1'b1;
          updown_pkg::FUNC_FWD_RUN: forward_run_command = 1'b1;
          updown_pkg::FUNC_REV_RUN: rev_in = 1'b1;
          default: ;
        endcase
      end
    end
  end

  // in latched mode the latch holds the run, otherwise the level does
  assign run_cmd = latch_in ? (fwd_latch | rev_latch) : (forward_run_command ^ rev_in);

  // register writes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < updown_pkg::TERM_COUNT; i++) begin
        input_function_assignment[i] <= updown_pkg::FUNC_NONE;
      end
      save_mode <= 1'b1;
      max_freq <= updown_pkg::MAX_FREQ_RESET;
      step <= updown_pkg::STEP_RESET;
      keypad_freq <= updown_pkg::FREQ_RESET;
      source_sel <= updown_pkg::SRC_ANALOG;
    end else if (clk_en && reg_wr) begin
      for (int i = 0; i < updown_pkg::TERM_COUNT; i++) begin
        if (reg_addr == updown_pkg::ADDR_FUNC_BASE + 8'(4 * i)) begin
          input_function_assignment[i] <= reg_wdata[5:0];
        end
      end
      if (reg_addr == updown_pkg::ADDR_SAVE_MODE) begin
        save_mode <= reg_wdata[0];
      end
      if (reg_addr == updown_pkg::ADDR_MAX_FREQ) begin
        max_freq <= reg_wdata[15:0];
      end
      if (reg_addr == updown_pkg::ADDR_STEP) begin
        step <= reg_wdata[15:0];
      end
      // keypad edits are dropped while up-down control owns the frequency
      if (reg_addr == updown_pkg::ADDR_KEYPAD_FREQ && !en_in) begin
        keypad_freq <= reg_wdata[15:0];
      end
      if (reg_addr == updown_pkg::ADDR_SOURCE) begin
        source_sel <= reg_wdata[1:0];
      end
    end
  end

  // register reads, data in the following cycle only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        for (int i = 0; i < updown_pkg::TERM_COUNT; i++) begin
          if (reg_addr == updown_pkg::ADDR_FUNC_BASE + 8'(4 * i)) begin
            reg_rdata <= {26'h000_0000, input_function_assignment[i]};
          end
        end
        unique case (reg_addr)
          updown_pkg::ADDR_SAVE_MODE: reg_rdata <= {31'h0000_0000, save_mode};
          updown_pkg::ADDR_MAX_FREQ: reg_rdata <= {16'h0000, max_freq};
          updown_pkg::ADDR_STEP: reg_rdata <= {16'h0000, step};
          updown_pkg::ADDR_KEYPAD_FREQ: reg_rdata <= {16'h0000, keypad_freq};
          updown_pkg::ADDR_SOURCE: reg_rdata <= {30'h0000_0000, source_sel};
          updown_pkg::ADDR_STATUS: reg_rdata <= {24'h00_0000, saved_valid, rev_latch,
                                                 fwd_latch, en_in, state};
          updown_pkg::ADDR_OUT_FREQ: reg_rdata <= {16'h0000, freq_ref};
          updown_pkg::ADDR_SAVED_FREQ: reg_rdata <= {16'h0000, saved_freq};
          default: ;
        endcase
      end
    end
  end

  // ramp tick divider
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (clk_en) begin
      tick <= (tick_cnt == 16'(updown_pkg::RAMP_TICK_CYCLES - 1));
      if (tick_cnt == 16'(updown_pkg::RAMP_TICK_CYCLES - 1)) begin
        tick_cnt <= '0;
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
      end
    end
  end

  // ramp state: idle without enable or run, hold with both or neither of up and down, else ramp up or down
  always_comb begin
    next_state = updown_pkg::ST_HOLD;
    if (!en_in || !run_cmd) begin
      next_state = updown_pkg::ST_IDLE;
    end else if (up_in && down_in) begin
      next_state = updown_pkg::ST_HOLD;
    end else if (up_in) begin
      next_state = updown_pkg::ST_RAMP_UP;
    end else if (down_in) begin
      next_state = updown_pkg::ST_RAMP_DOWN;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= updown_pkg::ST_IDLE;
      ud_en_d <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      ud_en_d <= en_in;
    end
  end

  assign up_sum = {1'b0, ud_freq} + {1'b0, step};

  // up-down frequency, saved value and clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ud_freq <= updown_pkg::FREQ_RESET;
      saved_freq <= updown_pkg::FREQ_RESET;
      saved_valid <= 1'b0;
      run_d <= 1'b0;
      fault_d <= 1'b0;
      power_d <= 1'b0;
    end else if (clk_en) begin
      run_d <= run_cmd;
      fault_d <= fault_trip;
      power_d <= power_fail;
      if (en_in && !ud_en_d) begin
        // take over the saved frequency if valid, else the frequency in use at the moment of switchover
        ud_freq <= saved_valid ? saved_freq : freq_ref;
      end else if (tick && state == updown_pkg::ST_RAMP_UP) begin
        ud_freq <= (up_sum > {1'b0, max_freq}) ? max_freq : up_sum[15:0];
      end else if (tick && state == updown_pkg::ST_RAMP_DOWN) begin
        ud_freq <= (ud_freq > step) ? ud_freq - step : 16'h0000;
      end else if (ud_freq > max_freq) begin
        ud_freq <= max_freq;
      end else if (run_cmd && !run_d && saved_valid) begin
        ud_freq <= saved_freq;
      end
      if (clr_in && state == updown_pkg::ST_HOLD) begin
        saved_valid <= 1'b0;
        saved_freq <= updown_pkg::FREQ_RESET;
        ud_freq <= updown_pkg::FREQ_RESET;
      end else if (save_mode && state == updown_pkg::ST_HOLD &&
                   ((run_d && !run_cmd) || (fault_trip && !fault_d) ||
                    (power_fail && !power_d))) begin
        // only constant-speed frequency is kept
        saved_freq <= ud_freq;
        saved_valid <= 1'b1;
      end
    end
  end

  // latched push-button run; pulses under 1 ms are not guaranteed
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fwd_latch <= 1'b0;
      rev_latch <= 1'b0;
    end else if (clk_en) begin
      if (!latch_in) begin
        fwd_latch <= 1'b0;
        rev_latch <= 1'b0;
      end else if (forward_run_command && rev_in) begin
        fwd_latch <= 1'b0;
        rev_latch <= 1'b0;
      end else if (forward_run_command) begin
        fwd_latch <= 1'b1;
        rev_latch <= 1'b0;
      end else if (rev_in) begin
        rev_latch <= 1'b1;
        fwd_latch <= 1'b0;
      end
    end
  end

  // outputs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      freq_ref <= updown_pkg::FREQ_RESET;
      run_fwd <= 1'b0;
      run_rev <= 1'b0;
      updown_active <= 1'b0;
    end else if (clk_en) begin
      updown_active <= en_in;
      run_fwd <= latch_in ? fwd_latch : (forward_run_command && !rev_in);
      run_rev <= latch_in ? rev_latch : (rev_in && !forward_run_command);
      if (en_in && ud_en_d) begin
        freq_ref <= ud_freq;
      end else if (en_in) begin
        freq_ref <= freq_ref;
      end else if (source_sel == updown_pkg::SRC_ANALOG) begin
        freq_ref <= analog_voltage_reference;
      end else if (source_sel == updown_pkg::SRC_KEYPAD) begin
        freq_ref <= keypad_freq;
      end else begin
        freq_ref <= normal_ramp_freq;
      end
    end
  end
endmodule // updown_run_ctrl

// >>> dv/updown_run_ctrl_properties.sv
// port checker for the up-down and latched run control
module updown_run_ctrl_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // watched ports
  input wire logic [updown_pkg::TERM_COUNT-1:0] term_in,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] freq_ref,
  input wire logic run_fwd,
  input wire logic run_rev,
  input wire logic updown_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // a step lands, then nothing moves for a while: ticks are 1 ms apart
  sequence ud_step_s;
    updown_active && $past(updown_active) && $changed(freq_ref);
  endsequence
  sequence ud_flat_s;
    (!updown_active || $stable(freq_ref)) [*8];
  endsequence
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  AST_RDATA_UPPER: assert property (reg_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  AST_RESET_OUT: assert property ($past(!nrst) |-> freq_ref == 16'h0000 && !run_fwd && !run_rev)
    else $error("outputs not cleared after reset");
  // limit: assumes the maximum keeps its reset value
  AST_CLAMP: assert property (updown_active |-> freq_ref <= updown_pkg::MAX_FREQ_RESET)
    else $error("frequency above maximum");
  AST_RUN_EXCL: assert property (!(run_fwd && run_rev))
    else $error("both run directions active");
  AST_UD_ENTRY: assert property ($rose(updown_active) |-> $stable(freq_ref))
    else $error("frequency moved on switchover entry");
  AST_UD_STEP: assert property (ud_step_s |=> ud_flat_s)
    else $error("frequency stepped faster than the tick");
  AST_RUN_CAUSE: assert property ($rose(run_fwd) |-> $past(term_in) != 5'h00)
    else $error("run started with no terminal active");
endmodule // updown_run_ctrl_checker

bind updown_run_ctrl updown_run_ctrl_checker chk_u (.core_clk(core_clk), .nrst(nrst),
  .term_in(term_in), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .freq_ref(freq_ref),
  .run_fwd(run_fwd), .run_rev(run_rev), .updown_active(updown_active));

// >>> dv/terminal_switches.sv
// switch model: pins follow the presses, no press is stretched to the least pulse time
module terminal_switches (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // bench commands and pins
  input wire logic [4:0] press,
  output logic [4:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hold_cnt [5];
  always_ff @(posedge core_clk or negedge nrst) begin
    for (int i = 0; i < 5; i++) begin
      if (!nrst) begin
        hold_cnt[i] <= 16'h0000;
      end else if (press[i] && !pins[i]) begin
        // pins includes press, so this stretch load is never taken and hold_cnt stays zero
        hold_cnt[i] <= 16'(updown_pkg::MIN_PULSE_CYCLES - 1);
      end else if (hold_cnt[i] != 16'h0000) begin
        hold_cnt[i] <= hold_cnt[i] - 16'h0001;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pins[i] = press[i] | (hold_cnt[i] != 16'h0000);
    end
  end
endmodule // terminal_switches

// >>> dv/updown_run_ctrl_tb_top.sv
// self-checking bench for the up-down and latched run control
module updown_run_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] press = 5'h00;
  logic [4:0] term_in;
  logic [15:0] analog = 16'h0500;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] freq_ref;
  logic run_fwd;
  logic run_rev;
  logic updown_active;
  int n_fail = 0;
  int total_checks = 0;
  always #20 core_clk = ~core_clk;
  terminal_switches sw_u (.core_clk(core_clk), .nrst(nrst), .press(press), .pins(term_in));
  updown_run_ctrl dut_u (.core_clk(core_clk), .nrst(nrst), .clk_en(1'b1), .term_in(term_in),
    .fault_trip(1'b0), .power_fail(1'b0), .analog_voltage_reference(analog),
    .normal_ramp_freq(16'h0200), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .freq_ref(freq_ref),
    .run_fwd(run_fwd), .run_rev(run_rev), .updown_active(updown_active));
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask
  // terminals pass a synchroniser, so allow ten edges
  task automatic push(input logic [4:0] v);
    @(posedge core_clk);
    press <= v;
    repeat (10) @(posedge core_clk);
    #1;
  endtask
  // b below zero waits for a frequency change, else for terminal b to fall
  task automatic wait_for(input int b, input logic [15:0] f0);
    int n;
    n = 0;
    while ((b < 0 ? freq_ref === f0 : term_in[b] === 1'b1) && n < 30000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 30000) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic cfg(input logic [5:0] f0, f1, f2, f3, f4);
    logic [5:0] f [5];
    f = '{f0, f1, f2, f3, f4};
    for (int i = 0; i < 5; i++) begin
      wr(8'(4 * i), {26'h000_0000, f[i]});
    end
  endtask
  task automatic t_reset();
    rd(updown_pkg::ADDR_SAVE_MODE, 32'h0000_0001);
    rd(updown_pkg::ADDR_MAX_FREQ, 32'h0000_1770);
    rd(updown_pkg::ADDR_STEP, 32'h0000_0001);
    rd(updown_pkg::ADDR_SOURCE, 32'h0000_0001);
    rd(updown_pkg::ADDR_KEYPAD_FREQ, 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000);
  endtask
  task automatic t_updown();
    cfg(6'h01, 6'h11, 6'h12, 6'h1B, 6'h14);
    wr(updown_pkg::ADDR_STEP, 32'h0000_0100);
    push(5'h01);
    chk("freq_ref", 32'h0000_0500, 32'(freq_ref));
    chk("run_fwd", 32'h0000_0001, 32'(run_fwd));
    push(5'h09);
    chk("updown_active", 32'h0000_0001, 32'(updown_active));
    @(posedge core_clk);
    analog <= 16'h0700;
    push(5'h0B);
    wait_for(-1, 16'h0500);
    chk("freq_ref", 32'h0000_0600, 32'(freq_ref));
    push(5'h09);
    wait_for(1, 16'h0000);
    chk("freq_ref", 32'h0000_0600, 32'(freq_ref));
    push(5'h0D);
    wait_for(-1, 16'h0600);
    chk("freq_ref", 32'h0000_0500, 32'(freq_ref));
    push(5'h09);
    wait_for(2, 16'h0000);
    chk("freq_ref", 32'h0000_0500, 32'(freq_ref));
    wr(updown_pkg::ADDR_KEYPAD_FREQ, 32'h0000_0123);
    rd(updown_pkg::ADDR_KEYPAD_FREQ, 32'h0000_0000);
    push(5'h08);
    rd(updown_pkg::ADDR_SAVED_FREQ, 32'h0000_0500);
    push(5'h09);
    chk("freq_ref", 32'h0000_0500, 32'(freq_ref));
    push(5'h19);
    rd(updown_pkg::ADDR_SAVED_FREQ, 32'h0000_0000);
    chk("freq_ref", 32'h0000_0000, 32'(freq_ref));
    push(5'h00);
  endtask
  task automatic t_latched();
    cfg(6'h01, 6'h02, 6'h0E, 6'h00, 6'h00);
    push(5'h04);
    push(5'h05);
    push(5'h04);
    wait_for(0, 16'h0000);
    chk("run_fwd", 32'h0000_0001, 32'(run_fwd));
    push(5'h00);
    chk("run_fwd", 32'h0000_0000, 32'(run_fwd));
    push(5'h04);
    push(5'h05);
    chk("run_fwd", 32'h0000_0001, 32'(run_fwd));
    push(5'h07);
    chk("run_fwd", 32'h0000_0000, 32'(run_fwd));
    chk("run_rev", 32'h0000_0000, 32'(run_rev));
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_updown();
    t_latched();
    print_verdict();
  end
endmodule // updown_run_ctrl_tb_top
